// ### tif_pkg.sv
package tif_pkg;
    // channel count and widths
    localparam int NUM_CH = 5;
    localparam int ADDR_W = 28;
    localparam int DATA_W = 16;
    localparam int DIV_W = 10;
    // filter register offsets and reset value
    localparam logic [27:0] FILT01_ADDR = 28'hFFFFF54;
    localparam logic [27:0] FILT23_ADDR = 28'hFFFFF59;
    localparam logic [27:0] FILT4_ADDR = 28'hFFFFF69;
    localparam logic [7:0] FILT_RESET = 8'h00;
    // input route register offset and reset value
    localparam logic [27:0] ROUTE_ADDR = 28'hFFFFF4F;
    localparam logic [7:0] ROUTE_RESET = 8'h00;
    // input route field positions
    localparam int ROUTE_CH4_STAMP = 0;
    localparam int ROUTE_CH2_SERIAL = 1;
    localparam int ROUTE_CH3_SERIAL = 2;
    localparam int ROUTE_CH2_CHAIN = 3;
    localparam int ROUTE_CH2_LOC = 5;
    // per-channel register window: base + channel * stride + index
    localparam logic [27:0] CH_BASE = 28'hFFFFF80;
    localparam logic [27:0] CH_STRIDE = 28'h0000010;
    localparam logic [3:0] IDX_CTRL_A = 4'h0;
    localparam logic [3:0] IDX_CTRL_B = 4'h1;
    localparam logic [3:0] IDX_CMP0 = 4'h2;
    localparam logic [3:0] IDX_CMP1 = 4'h4;
    localparam logic [3:0] IDX_COUNT = 4'h6;
    localparam logic [3:0] IDX_STATUS = 4'h7;
    // control field positions
    localparam int CA_ENABLE = 7;
    localparam int CB_SYNC = 7;
    localparam int CB_SOFT_TRIG = 6;
    localparam int CB_EXT_EVENT = 5;
    localparam int NF_ENABLE = 3;
    localparam int ST_OVF = 0;
    localparam int ST_FILT_READY = 1;
    // filter settle count in sampling clocks
    localparam logic [1:0] FILT_SETTLE = 2'h3;
    // sample code meaning the low-speed oscillator
    localparam logic [3:0] EXP_LOW_OSC = 4'hF;
    // counter constants
    localparam logic [15:0] CNT_IDLE = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    // operating modes
    typedef enum logic [2:0] {
        MODE_INTERVAL, MODE_EVENT, MODE_TRIG_PULSE, MODE_ONE_SHOT,
        MODE_PWM, MODE_FREE_RUN, MODE_PULSE_WIDTH, MODE_SPARE
    } tif_mode_e;
    // decoded channel control
    typedef struct packed {
        logic count_en;
        logic [2:0] count_clk_sel;
        logic sync_join;
        logic ext_event;
        tif_mode_e mode;
    } tif_ctrl_s;
endpackage : tif_pkg

// ### tif_timer.sv
// Notes on behaviour
// - route bit picks chain from channel 3
// - route bit feeds serial B into channel 3
// - route bit feeds serial A into channel 2
// - route bit feeds CAN stamp into channel 4
// - per-channel filter enable, nibbles paired per register, ch4 alone in the last
// - three-bit code selects filter sampling clock
// - filter needs three samples after clock change
// - channel 0 master, others join by bit
// - slave compare handover on write or match
// - synchronised PWM drives both slave outputs
// - mode decides triggers and compare write style
// - mode 000 interval timing with square wave
// - enable wraps FFFF to 0000, toggles, loads
// - compare-0 match clears, toggles, raises interrupt
// - period is compare-0 plus one counts
// - compare-1 still matches and interrupts
// - io and option settings ignored here
// - compare-0 zero keeps counter at zero
// - compare-0 FFFF wraps without overflow flag
//
// The address-and-strobe port was decided locally.
module tif_timer (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic [27:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic [4:0] chan_pin_zero_in,
    input wire logic [4:0] chan_pin_one_in,
    input wire logic chan2_pin_zero_alt_in,
    input wire logic serial_a_receive_in,
    input wire logic serial_b_receive_in,
    input wire logic can_stamp_output_in,
    input wire logic low_osc_tick_in,
    output logic [4:0] chan_pin_zero_out,
    output logic [4:0] chan_pin_one_out,
    output logic [4:0] match_zero_irq_out,
    output logic [4:0] match_one_irq_out,
    output logic [4:0] overflow_irq_out
);
    localparam int N = tif_pkg::NUM_CH;

    // true when the low k bits of the free divider are all ones
    function automatic logic div_tick(input logic [9:0] div, input logic [3:0] k);
        logic [9:0] mask;
        mask = 10'(({10'h0, 1'b1} << k) - 1);
        div_tick = ((div & mask) == mask);
    endfunction : div_tick

    // sampling exponent per channel and code; ch2 and ch3 deviate
    function automatic logic [3:0] samp_exp(input int ch, input logic [2:0] code);
        samp_exp = {1'b0, code};
        if (ch == 2 && code == 3'h3) begin
            samp_exp = 4'h8;
        end else if (ch == 2 && code == 3'h4) begin
            samp_exp = 4'h9;
        end else if (ch == 3 && code == 3'h7) begin
            samp_exp = tif_pkg::EXP_LOW_OSC;
        end
    endfunction : samp_exp

    // register state
    logic [7:0] filt_q [3]; // filter control registers
    logic [7:0] route_q; // input route select
    logic [7:0] ctrl_a_q [N]; // enable and count clock
    logic [7:0] ctrl_b_q [N]; // sync, event clock, mode
    logic [15:0] cmp0_q [N]; // compare 0 as written
    logic [15:0] cmp1_q [N]; // compare 1 as written
    logic [9:0] div_q; // free prescaler
    logic [15:0] rdata_q; // read data register

    // channel state
    logic [15:0] cnt_q [N];
    logic [15:0] cnt_d [N];
    logic [15:0] buf0_q [N];
    logic [15:0] buf1_q [N];
    logic [N-1:0] started_q;
    logic [N-1:0] ovf_q;
    logic [N-1:0] out0_q;
    logic [N-1:0] out1_q;
    logic [N-1:0] irq0_q;
    logic [N-1:0] irq1_q;
    logic [N-1:0] irqov_q;

    // filter state, index ch*2 + input
    logic [1:0] hist_q [2*N];
    logic [2*N-1:0] fout_q;
    logic [1:0] settle_q [N];
    logic [3:0] exp_q [N];
    logic [N-1:0] nfen_q;
    logic [N-1:0] fpin0_q; // previous filtered first input

    // wires shared between channels
    tif_pkg::tif_ctrl_s ctrl [N];
    logic [3:0] nf_nib [N];
    logic [N-1:0] raw0;
    logic [N-1:0] raw1;
    logic [2*N-1:0] fin;
    logic [N-1:0] step;
    logic [N-1:0] own_step; // own strobe
    logic [N-1:0] first;
    logic [N-1:0] match0;
    logic [N-1:0] match1;
    logic [N-1:0] cmp0_wr;
    logic [N-1:0] cmp1_wr;
    logic [N-1:0] ctrlb_wr;
    logic [N-1:0] filt_ready;

    // filter nibbles: ch0 low / ch1 high, ch2 low / ch3 high, ch4 low
    assign nf_nib[0] = filt_q[0][3:0];
    assign nf_nib[1] = filt_q[0][7:4];
    assign nf_nib[2] = filt_q[1][3:0];
    assign nf_nib[3] = filt_q[1][7:4];
    assign nf_nib[4] = filt_q[2][3:0];

    // input routing for the channel inputs
    assign raw0[0] = chan_pin_zero_in[0];
    assign raw0[1] = chan_pin_zero_in[1];
    assign raw0[2] = route_q[tif_pkg::ROUTE_CH2_SERIAL] ? serial_a_receive_in
        : (route_q[tif_pkg::ROUTE_CH2_LOC] ? chan2_pin_zero_alt_in : chan_pin_zero_in[2]);
    assign raw0[3] = route_q[tif_pkg::ROUTE_CH3_SERIAL] ? serial_b_receive_in
        : chan_pin_zero_in[3];
    assign raw0[4] = route_q[tif_pkg::ROUTE_CH4_STAMP] ? can_stamp_output_in
        : chan_pin_zero_in[4];
    assign raw1[1:0] = chan_pin_one_in[1:0];
    assign raw1[2] = route_q[tif_pkg::ROUTE_CH2_CHAIN] ? out0_q[3]
        : chan_pin_one_in[2];
    assign raw1[4:3] = chan_pin_one_in[4:3];

    // bus decode and register writes
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            filt_q <= '{default: tif_pkg::FILT_RESET};
            route_q <= tif_pkg::ROUTE_RESET;
            div_q <= '0;
        end else if (clk_en_in) begin
            div_q <= 10'(div_q + 10'h001);
            if (reg_wr_in && reg_addr_in == tif_pkg::FILT01_ADDR) begin
                filt_q[0] <= reg_wdata_in[7:0];
            end
            if (reg_wr_in && reg_addr_in == tif_pkg::FILT23_ADDR) begin
                filt_q[1] <= reg_wdata_in[7:0];
            end
            // upper nibble of the last filter register is reserved
            if (reg_wr_in && reg_addr_in == tif_pkg::FILT4_ADDR) begin
                filt_q[2] <= {4'h0, reg_wdata_in[3:0]};
            end
            if (reg_wr_in && reg_addr_in == tif_pkg::ROUTE_ADDR) begin
                route_q <= {reg_wdata_in[7:5], 1'b0, reg_wdata_in[3:0]};
            end
        end
    end

    // read mux, data stands one cycle after the strobe only
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (reg_addr_in == tif_pkg::FILT01_ADDR) rd_mux = {8'h00, filt_q[0]};
        if (reg_addr_in == tif_pkg::FILT23_ADDR) rd_mux = {8'h00, filt_q[1]};
        if (reg_addr_in == tif_pkg::FILT4_ADDR) rd_mux = {8'h00, filt_q[2]};
        if (reg_addr_in == tif_pkg::ROUTE_ADDR) rd_mux = {8'h00, route_q};
        for (int c = 0; c < N; c++) begin
            logic [27:0] base;
            base = 28'(tif_pkg::CH_BASE + 28'(c) * tif_pkg::CH_STRIDE);
            if (reg_addr_in == 28'(base + 28'(tif_pkg::IDX_CTRL_A))) begin
                rd_mux = {8'h00, ctrl_a_q[c]};
            end
            // the trigger bit always reads as zero
            if (reg_addr_in == 28'(base + 28'(tif_pkg::IDX_CTRL_B))) begin
                rd_mux = {8'h00, ctrl_b_q[c] & 8'hBF};
            end
            if (reg_addr_in == 28'(base + 28'(tif_pkg::IDX_CMP0))) rd_mux = cmp0_q[c];
            if (reg_addr_in == 28'(base + 28'(tif_pkg::IDX_CMP1))) rd_mux = cmp1_q[c];
            // counter reads zero while counting is disabled
            if (reg_addr_in == 28'(base + 28'(tif_pkg::IDX_COUNT))) begin
                rd_mux = ctrl[c].count_en ? cnt_q[c] : tif_pkg::CNT_ZERO;
            end
            if (reg_addr_in == 28'(base + 28'(tif_pkg::IDX_STATUS))) begin
                rd_mux = {14'h0000, filt_ready[c], ovf_q[c]};
            end
        end
    end

    // registered read data
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rdata_q <= 16'h0000;
        end else if (clk_en_in) begin
            rdata_q <= reg_rd_in ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign chan_pin_zero_out = out0_q;
    assign chan_pin_one_out = out1_q;
    assign match_zero_irq_out = irq0_q;
    assign match_one_irq_out = irq1_q;
    assign overflow_irq_out = irqov_q;

    // one instance of channel logic per timer
    for (genvar c = 0; c < N; c++) begin : g_ch
        localparam logic [27:0] BASE = 28'(tif_pkg::CH_BASE + 28'(c) * tif_pkg::CH_STRIDE);
        logic [3:0] exp_now; // requested sampling exponent
        logic samp_tick; // filter sampling strobe
        logic cnt_tick; // count clock strobe, prescaler or external edge
        logic ev_edge; // rising edge of filtered first input
        logic slave; // synchronised slave
        logic batch; // compare writes wait for period end
        logic trig; // restart request honoured in trigger modes
        logic soft_wr; // software trigger written
        logic pwm_sync; // synchronised PWM on a slave
        logic wrap; // period end for this channel
        logic ovf_ev; // natural FFFF to 0000 wrap

        // field decode of the control registers
        assign ctrl[c].count_en = ctrl_a_q[c][tif_pkg::CA_ENABLE];
        assign ctrl[c].count_clk_sel = ctrl_a_q[c][2:0];
        assign ctrl[c].sync_join = (c != 0) && ctrl_b_q[c][tif_pkg::CB_SYNC];
        assign ctrl[c].ext_event = ctrl_b_q[c][tif_pkg::CB_EXT_EVENT];
        assign ctrl[c].mode = tif_pkg::tif_mode_e'(ctrl_b_q[c][2:0]);
        assign cmp0_wr[c] = reg_wr_in && reg_addr_in == 28'(BASE + 28'(tif_pkg::IDX_CMP0));
        assign cmp1_wr[c] = reg_wr_in && reg_addr_in == 28'(BASE + 28'(tif_pkg::IDX_CMP1));
        assign ctrlb_wr[c] = reg_wr_in && reg_addr_in == 28'(BASE + 28'(tif_pkg::IDX_CTRL_B));

        // sampling clock per code, low-speed oscillator where mapped
        assign exp_now = samp_exp(c, nf_nib[c][2:0]);
        assign samp_tick = (exp_now == tif_pkg::EXP_LOW_OSC) ? low_osc_tick_in
            : div_tick(div_q, exp_now);
        assign filt_ready[c] = (settle_q[c] == tif_pkg::FILT_SETTLE);

        // bypass when disabled, else the filtered level
        assign fin[2*c] = nfen_q[c] ? fout_q[2*c] : raw0[c];
        assign fin[2*c+1] = nfen_q[c] ? fout_q[2*c+1] : raw1[c];

        // count strobe: prescaler or filtered external edge
        assign ev_edge = fin[2*c] && !fpin0_q[c];
        assign cnt_tick = ctrl[c].ext_event ? ev_edge : div_tick(div_q, {1'b0, ctrl[c].count_clk_sel});

        // slave follows master timing when joined and master enabled
        assign slave = ctrl[c].sync_join && ctrl[0].count_en;
        assign own_step[c] = ctrl[c].count_en && cnt_tick;
        assign step[c] = slave ? own_step[0] : own_step[c];
        assign first[c] = step[c] && !started_q[c];
        assign match0[c] = step[c] && started_q[c] && (cnt_q[c] == buf0_q[c]);
        assign match1[c] = step[c] && started_q[c] && (cnt_q[c] == buf1_q[c]);
        assign wrap = slave ? (first[0] || match0[0]) : (first[c] || match0[c]);
        assign ovf_ev = step[c] && started_q[c] && !slave && !match0[c]
            && (cnt_q[c] == tif_pkg::CNT_IDLE);

        // triggers only in trigger pulse and one-shot modes
        assign soft_wr = ctrlb_wr[c] && reg_wdata_in[tif_pkg::CB_SOFT_TRIG];
        assign trig = (ctrl[c].mode == tif_pkg::MODE_TRIG_PULSE
            || ctrl[c].mode == tif_pkg::MODE_ONE_SHOT) && started_q[c] && (soft_wr || ev_edge);
        // batch loading in trigger pulse and PWM modes
        assign batch = (ctrl[c].mode == tif_pkg::MODE_TRIG_PULSE
            || ctrl[c].mode == tif_pkg::MODE_PWM);
        assign pwm_sync = slave && ctrl[0].mode == tif_pkg::MODE_PWM;

        // next count: slave copies master, compare 0 clears, else up
        always_comb begin
            cnt_d[c] = cnt_q[c];
            if (!ctrl[c].count_en) begin
                cnt_d[c] = tif_pkg::CNT_IDLE;
            end else if (slave) begin
                cnt_d[c] = cnt_d[0];
            end else if (first[c] || match0[c] || trig) begin
                cnt_d[c] = tif_pkg::CNT_ZERO;
            end else if (step[c]) begin
                cnt_d[c] = 16'(cnt_q[c] + 16'h0001);
            end
        end

        // control and compare registers of this channel
        always_ff @(posedge ref_clk_in) begin
            if (reset_in) begin
                ctrl_a_q[c] <= 8'h00;
                ctrl_b_q[c] <= 8'h00;
                cmp0_q[c] <= 16'h0000;
                cmp1_q[c] <= 16'h0000;
            end else if (clk_en_in) begin
                if (reg_wr_in && reg_addr_in == 28'(BASE + 28'(tif_pkg::IDX_CTRL_A))) begin
                    ctrl_a_q[c] <= reg_wdata_in[7:0];
                end
                if (ctrlb_wr[c]) begin
                    ctrl_b_q[c] <= reg_wdata_in[7:0];
                end
                if (cmp0_wr[c]) begin
                    cmp0_q[c] <= reg_wdata_in;
                end
                if (cmp1_wr[c]) begin
                    cmp1_q[c] <= reg_wdata_in;
                end
            end
        end

        // noise filter: three equal samples move the output
        always_ff @(posedge ref_clk_in) begin
            if (reset_in) begin
                hist_q[2*c] <= 2'h0;
                hist_q[2*c+1] <= 2'h0;
                fout_q[2*c+1:2*c] <= 2'h0;
                settle_q[c] <= 2'h0;
                exp_q[c] <= 4'h0;
                nfen_q[c] <= 1'b0;
                fpin0_q[c] <= 1'b0;
            end else if (clk_en_in) begin
                exp_q[c] <= exp_now;
                nfen_q[c] <= nf_nib[c][tif_pkg::NF_ENABLE];
                fpin0_q[c] <= fin[2*c];
                if (exp_now != exp_q[c] || !nf_nib[c][tif_pkg::NF_ENABLE]) begin
                    // clock change or disable restarts settling
                    settle_q[c] <= 2'h0;
                end else if (samp_tick) begin
                    hist_q[2*c] <= {hist_q[2*c][0], raw0[c]};
                    hist_q[2*c+1] <= {hist_q[2*c+1][0], raw1[c]};
                    if (!filt_ready[c]) begin
                        settle_q[c] <= 2'(settle_q[c] + 2'h1);
                    end
                    // output only follows once settled
                    if (filt_ready[c] && hist_q[2*c] == {2{raw0[c]}}) begin
                        fout_q[2*c] <= raw0[c];
                    end
                    if (filt_ready[c] && hist_q[2*c+1] == {2{raw1[c]}}) begin
                        fout_q[2*c+1] <= raw1[c];
                    end
                end
            end
        end

        // counter, buffers, outputs and event pulses
        always_ff @(posedge ref_clk_in) begin
            if (reset_in) begin
                cnt_q[c] <= tif_pkg::CNT_IDLE;
                buf0_q[c] <= 16'h0000;
                buf1_q[c] <= 16'h0000;
                started_q[c] <= 1'b0;
                ovf_q[c] <= 1'b0;
                out0_q[c] <= 1'b0;
                out1_q[c] <= 1'b0;
                irq0_q[c] <= 1'b0;
                irq1_q[c] <= 1'b0;
                irqov_q[c] <= 1'b0;
            end else if (clk_en_in) begin
                cnt_q[c] <= cnt_d[c];
                irq0_q[c] <= match0[c];
                irq1_q[c] <= match1[c];
                irqov_q[c] <= ovf_ev;
                // overflow flag: a wrap in the clearing cycle wins
                if (ovf_ev) begin
                    ovf_q[c] <= 1'b1;
                end else if (reg_wr_in && reg_addr_in == 28'(BASE + 28'(tif_pkg::IDX_STATUS))
                    && !reg_wdata_in[tif_pkg::ST_OVF]) begin
                    ovf_q[c] <= 1'b0;
                end
                // started tracks the first count after enable
                if (!ctrl[c].count_en) begin
                    started_q[c] <= 1'b0;
                end else if (first[c]) begin
                    started_q[c] <= 1'b1;
                end
                // buffer load at start; per mode on write or at period end
                if (first[c]) begin
                    buf0_q[c] <= cmp0_q[c];
                    buf1_q[c] <= cmp1_q[c];
                end else if (slave && ctrl[0].mode != tif_pkg::MODE_FREE_RUN) begin
                    if (wrap) begin
                        buf0_q[c] <= cmp0_q[c];
                        buf1_q[c] <= cmp1_q[c];
                    end
                end else if (batch && !slave) begin
                    if (match0[c]) begin
                        buf0_q[c] <= cmp0_q[c];
                        buf1_q[c] <= cmp1_q[c];
                    end
                end else if (started_q[c]) begin
                    // anytime write, also slaves of a free-running master
                    if (cmp0_wr[c]) buf0_q[c] <= reg_wdata_in;
                    if (cmp1_wr[c]) buf1_q[c] <= reg_wdata_in;
                end
                // outputs: io settings have no say in this core
                if (pwm_sync) begin
                    // both slave pins high from period start to own match
                    if (match0[c]) begin
                        out0_q[c] <= 1'b0;
                    end else if (wrap) begin
                        out0_q[c] <= 1'b1;
                    end
                    if (match1[c]) begin
                        out1_q[c] <= 1'b0;
                    end else if (wrap) begin
                        out1_q[c] <= 1'b1;
                    end
                end else begin
                    // square wave, half period equals the interval
                    if (first[c] || match0[c]) begin
                        out0_q[c] <= !out0_q[c];
                    end
                    if (match1[c]) begin
                        out1_q[c] <= !out1_q[c];
                    end
                end
            end
        end
    end : g_ch
endmodule : tif_timer

// ### tif_timer_props.sv
module tif_timer_props (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic [4:0] chan_pin_zero_out,
    input wire logic [4:0] match_zero_irq_out,
    input wire logic [4:0] match_one_irq_out,
    input wire logic [4:0] overflow_irq_out
);
    // one clock domain, reset masks every check
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    rdata_idle_a: assert property (clk_en_in && !reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data not idle");
    reset_clear_a: assert property ($fell(reset_in) |-> reg_rdata_out == 16'h0000
        && chan_pin_zero_out == 5'h00) else $error("outputs not cleared by reset");
    match_toggle_a: assert property ($past(clk_en_in) |->
        ((chan_pin_zero_out ^ $past(chan_pin_zero_out)) & match_zero_irq_out) == match_zero_irq_out)
        else $error("match without output toggle");
    no_ovf_match_a: assert property ((overflow_irq_out & match_zero_irq_out) == 5'h00)
        else $error("overflow beside compare match");
    irq0_pulse_a: assert property ($past(clk_en_in) |->
        (match_zero_irq_out & $past(match_zero_irq_out)) == 5'h00) else $error("irq0 too long");
    irq1_pulse_a: assert property (match_one_irq_out != 5'h00 && clk_en_in |=>
        (match_one_irq_out & $past(match_one_irq_out)) == 5'h00) else $error("irq1 too long");
    ovf_pulse_a: assert property (overflow_irq_out != 5'h00 && clk_en_in |=>
        (overflow_irq_out & $past(overflow_irq_out)) == 5'h00) else $error("overflow too long");
    freeze_hold_a: assert property (!clk_en_in |=> $stable(chan_pin_zero_out)
        && $stable(reg_rdata_out)) else $error("outputs moved while frozen");
    irq0_seen_c: cover property (match_zero_irq_out[0]);
    irq1_seen_c: cover property (match_one_irq_out[0]);
    freeze_c: cover property (!clk_en_in ##1 clk_en_in);
endmodule : tif_timer_props
bind tif_timer tif_timer_props u_tif_timer_props (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .clk_en_in(clk_en_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .chan_pin_zero_out(chan_pin_zero_out), .match_zero_irq_out(match_zero_irq_out),
    .match_one_irq_out(match_one_irq_out), .overflow_irq_out(overflow_irq_out));

// ### tif_far_side.sv
module tif_far_side (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic go_in,
    input wire logic [4:0] pat_in,
    output logic [4:0] pin_zero_out,
    output logic [4:0] pin_one_out,
    output logic alt_out,
    output logic ser_a_out,
    output logic ser_b_out,
    output logic stamp_out,
    output logic osc_tick_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] osc_q; // slow oscillator divider
    // pins stay quiet until the timers run
    assign pin_zero_out = go_in ? pat_in : 5'h00;
    assign pin_one_out = go_in ? ~pat_in : 5'h00;
    assign alt_out = go_in & pat_in[2];
    // serial receive lines idle high
    assign ser_a_out = go_in ? pat_in[0] : 1'b1;
    assign ser_b_out = go_in ? pat_in[1] : 1'b1;
    assign stamp_out = go_in & pat_in[4];
    assign osc_tick_out = (osc_q == 4'hF);
    // slow tick once every sixteen cycles
    always_ff @(posedge ref_clk_in) begin
        osc_q <= reset_in ? 4'h0 : osc_q + 4'h1;
    end
endmodule : tif_far_side

// ### tif_timer_bench.sv
module tif_timer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_in, reset_in, clk_en, rd, wr, go, alt, sa, sb, st, tk;
    logic [27:0] addr;
    logic [15:0] wd, rdata, v;
    logic [4:0] pat, p0, p1, o0, o1, i0, i1, ov;
    logic [27:0] fa [3] = '{tif_pkg::FILT01_ADDR, tif_pkg::FILT23_ADDR, tif_pkg::FILT4_ADDR};
    int err_total = 0, compares = 0, seed = 32'h6B3B, n, m, d, k;
    tif_far_side u_tif_far_side (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .go_in(go),
        .pat_in(pat), .pin_zero_out(p0), .pin_one_out(p1), .alt_out(alt), .ser_a_out(sa),
        .ser_b_out(sb), .stamp_out(st), .osc_tick_out(tk));
    tif_timer u_tif_timer (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .clk_en_in(clk_en),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .chan_pin_zero_in(p0), .chan_pin_one_in(p1), .chan2_pin_zero_alt_in(alt),
        .serial_a_receive_in(sa), .serial_b_receive_in(sb), .can_stamp_output_in(st),
        .low_osc_tick_in(tk), .chan_pin_zero_out(o0), .chan_pin_one_out(o1),
        .match_zero_irq_out(i0), .match_one_irq_out(i1), .overflow_irq_out(ov));
    // free-running clock
    initial begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    // random pin activity
    always @(posedge ref_clk_in) pat <= 5'($random(seed));
    // channel 0 register address
    function automatic logic [27:0] ca(input logic [3:0] i);
        return tif_pkg::CH_BASE + {24'h000000, i};
    endfunction : ca
    // expected interval in clock cycles
    function automatic int period(input int dv, input int kv);
        return (dv + 1) << kv;
    endfunction : period
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [27:0] a, input logic [15:0] dv);
        @(posedge ref_clk_in);
        wr <= 1'b1;
        addr <= a;
        wd <= dv;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [27:0] a, output logic [15:0] dv);
        @(posedge ref_clk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        #1 dv = rdata;
    endtask : rd_reg
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // cycles to the next channel 0 match, with compare-1 hits
    task automatic wait_irq(output int nc, output int mc);
        nc = 0;
        mc = 0;
        do begin
            @(posedge ref_clk_in);
            #1 nc++;
            mc += (i1[0] === 1'b1);
        end while (i0[0] !== 1'b1 && nc < 5000);
        if (nc >= 5000) begin
            err_total++;
            end_sim();
        end
    endtask : wait_irq
    initial begin
        reset_in = 1'b1;
        clk_en = 1'b1;
        {rd, wr, go, addr, wd} = '0;
        repeat (5) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        rd_reg(ca(tif_pkg::IDX_COUNT), v); chk("count idle", v, 16'h0000);
        rd_reg(28'h0000100, v); chk("unmapped", v, 16'h0000);
        rd_reg(tif_pkg::ROUTE_ADDR, v); chk("route reset", v, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            rd_reg(fa[i], v); chk("filter reset", v, 16'h0000);
            d = $random(seed);
            wr_reg(fa[i], {8'h00, d[7:0]});
            rd_reg(fa[i], v); chk("filter rw", v, {8'h00, d[7:0] & (i == 2 ? 8'h0F : 8'hFF)});
        end
        d = $random(seed);
        wr_reg(tif_pkg::ROUTE_ADDR, {8'h00, d[7:0]});
        rd_reg(tif_pkg::ROUTE_ADDR, v); chk("route rw", v, {8'h00, d[7:0] & 8'hEF});
        wr_reg(tif_pkg::FILT01_ADDR, 16'h0000);
        wr_reg(tif_pkg::FILT01_ADDR, 16'h0008);
        rd_reg(ca(tif_pkg::IDX_STATUS), v); chk("settle early", v & 16'h0002, 16'h0000);
        repeat (4) @(posedge ref_clk_in);
        rd_reg(ca(tif_pkg::IDX_STATUS), v); chk("settled", v & 16'h0002, 16'h0002);
        go <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            k = c;
            wr_reg(tif_pkg::FILT01_ADDR, 16'(8 + k));
            repeat (12) @(posedge ref_clk_in);
            d = (c == 1) ? 0 : 1 + ($random(seed) & 7);
            wr_reg(ca(tif_pkg::IDX_CTRL_B), 16'h0000);
            wr_reg(ca(tif_pkg::IDX_CMP0), d[15:0]);
            wr_reg(ca(tif_pkg::IDX_CMP1), 16'h0000);
            wr_reg(ca(tif_pkg::IDX_CTRL_A), {8'h00, 8'h80 | k[7:0]});
            wait_irq(n, m);
            v[4:0] = o1;
            wait_irq(n, m);
            chk("out1 toggle", 16'(o1[0] ^ v[0]), 16'h0001);
            chk("period", n[15:0], 16'(period(d, k)));
            chk("cmp1 hits", m[15:0], 16'h0001);
            rd_reg(ca(tif_pkg::IDX_COUNT), v); chk("count range", {15'h0000, v <= d[15:0]}, 16'h0001);
            if (c == 2) begin
                @(posedge ref_clk_in) clk_en <= 1'b0;
                repeat (4) @(posedge ref_clk_in);
                clk_en <= 1'b1;
            end
            wr_reg(ca(tif_pkg::IDX_CTRL_A), 16'h0000);
        end
        wr_reg(tif_pkg::FILT01_ADDR, 16'h0000);
        end_sim();
    end
endmodule : tif_timer_bench
